//--- boot_seq_pkg.sv
/*
  Shared constants for the boot voltage and power good sequencer: code widths,
  boot code table, extension timing and slew pacing, and the sequencer states.
  Assumes a 100 MHz system clock; the extension count is derived from that period.
*/
package boot_seq_pkg;

    // Regulator count and voltage code width.
    localparam int NUM_REG = 3;
    localparam int VID_W   = 7;

    // Clock period and the power good extension time.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PG_EXT_TIME_US = 20;
    localparam int PG_EXT_CYCLES  = (PG_EXT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Cycles between single code steps of the slew controller.
    localparam int SLEW_STEP_CYCLES = 50;

    // Boot codes chosen by the two serial link levels {clock, data}.
    localparam logic [VID_W-1:0] BOOT_CODE_0 = 7'h10;
    localparam logic [VID_W-1:0] BOOT_CODE_1 = 7'h20;
    localparam logic [VID_W-1:0] BOOT_CODE_2 = 7'h30;
    localparam logic [VID_W-1:0] BOOT_CODE_3 = 7'h40;

    // Reset values of held and output state.
    localparam logic [VID_W-1:0] HELD_CODE_RST = 7'h00;
    localparam logic [VID_W-1:0] DAC_CODE_RST  = 7'h00;

    // Sequencer states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        ST_OFF       = 3'b000,
        ST_BOOT      = 3'b001,
        ST_BOOT_HOLD = 3'b011,
        ST_RUN       = 3'b010,
        ST_FALL      = 3'b110,
        ST_FALL_HOLD = 3'b111
    } seq_state_e;

endpackage : boot_seq_pkg

//--- pg_ext_timer.sv
/*
  One-shot interval timer that times the power good extension.
  Assumes start and abort come from logic on the same clock.
*/
`timescale 1ns/10ps
module pg_ext_timer
    import boot_seq_pkg::*;
#(
    parameter int CYCLES = PG_EXT_CYCLES
)(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Control and result.
    input  wire logic start,
    input  wire logic abort,
    output logic      expired
);

    localparam int CNT_W = $clog2(CYCLES + 1);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             running;
    logic             next_running;
    logic             next_expired;

    // Counts CYCLES edges after start, then pulses expired for one cycle.
    always_comb begin
        next_cnt     = cnt;
        next_running = running;
        next_expired = 1'b0;
        if (abort) begin
            next_running = 1'b0;
        end else if (start) begin
            next_running = 1'b1;
            next_cnt     = CNT_W'(CYCLES - 1);
        end else if (running) begin
            if (cnt == '0) begin
                next_running = 1'b0;
                next_expired = 1'b1;
            end else begin
                next_cnt = cnt - CNT_W'(1);
            end
        end
    end

    // Registers the timer state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt     <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            running <= next_running;
            expired <= next_expired;
        end
    end

endmodule : pg_ext_timer

//--- boot_voltage_power_good_seq.sv
/*
  Sequencer of a three output regulator controller: boot code selection,
  held boot code and fallback, power good, thermal alert, supply undervoltage
  latch, gate drive overrides and output discharge.
  Assumes pin and comparator inputs are asynchronous, command and modulator
  inputs share SYS_CLK, and open-drain wires are resolved outside.
*/
// Overview of operation
// [RL1] Boot code follows two link bits before power good
// [RL2] Commands taken only once system power ok is high
// [RL3] Capture boot code at first power good rise
// [RL4] Shutdown pin rising clears the held boot code
// [RL5] Power ok falling returns regulators to held code
// [RL6] Power good low during fallback slew plus 20us
// [RL7] Later power ok rise keeps held code unchanged
// [RL8] Power good otherwise ignores the power ok level
// [RL9] Power good released only when all outputs good
// [RL10] Power good released while codes are slewing
// [RL11] Power good low 20us after boot voltage reached
// [RL12] Power good driven low while shut down
// [RL13] Skip mode blanks upper comparator on downward moves
// [RL14] Low gate low in shutdown, high on overvoltage
// [RL15] Skip mode turns low gate off at zero cross
// [RL16] High gates held low while shut down
// [RL17] Discharge switch on while core regulator shut down
// [RL18] Thermal alert low when hot, released in shutdown
// [RL19] Undervoltage latched, cleared by shutdown pin toggle
// [RL20] Extension delays timed by counter of 20us minimum
`timescale 1ns/10ps
module boot_voltage_power_good_seq
    import boot_seq_pkg::*;
#(
    parameter int SLEW_DIV = SLEW_STEP_CYCLES
)(
    // Clock and reset.
    input  wire logic             SYS_CLK,
    input  wire logic             RST_N,
    // Asynchronous pins.
    input  wire logic             SHUTDOWN_N,
    input  wire logic             SYSTEM_POWER_OK_IN,
    input  wire logic             SERIAL_VID_CLOCK,
    input  wire logic             SERIAL_VID_DATA,
    input  wire logic             THERMAL_SENSE_IN,
    input  wire logic             SUPPLY_UVLO_IN,
    input  wire logic             POWER_GOOD_OUT_I,
    input  wire logic             THERMAL_ALERT_N_I,
    // Asynchronous analog comparators.
    input  wire logic [2:0]       OUT_ABOVE_LOW,
    input  wire logic [2:0]       OUT_ABOVE_HIGH,
    input  wire logic [1:0]       OUT_OVERVOLT,
    input  wire logic [1:0]       ZERO_CROSS,
    // Command decoder and modulators on SYS_CLK.
    input  wire logic             CMD_VALID,
    input  wire logic [2:0]       CMD_SELECT,
    input  wire logic [VID_W-1:0] CMD_CODE,
    input  wire logic [2:0]       SKIP_MODE,
    input  wire logic [1:0]       PWM_HIGH_REQ,
    input  wire logic [1:0]       PWM_LOW_REQ,
    // Open-drain outputs.
    output logic                  POWER_GOOD_OUT_O,
    output logic                  POWER_GOOD_OUT_OE,
    output logic                  THERMAL_ALERT_N_O,
    output logic                  THERMAL_ALERT_N_OE,
    // Gate drive and discharge.
    output logic                  HIGH_SIDE_GATE_1,
    output logic                  HIGH_SIDE_GATE_2,
    output logic                  LOW_SIDE_GATE_1,
    output logic                  LOW_SIDE_GATE_2,
    output logic                  CURRENT_SENSE_NEG_1_DISCHARGE,
    output logic                  CURRENT_SENSE_NEG_2_DISCHARGE,
    // Output DAC codes.
    output logic [VID_W-1:0]      DAC_CODE_1,
    output logic [VID_W-1:0]      DAC_CODE_2,
    output logic [VID_W-1:0]      DAC_CODE_3
);

    localparam int NS     = 17;
    localparam int SLEW_W = $clog2(SLEW_DIV + 1);
    localparam int HOLD_W = $clog2(PG_EXT_CYCLES + 2);

    // Synchroniser chain and filtered levels.
    logic [NS-1:0]    pin_raw;
    logic [NS-1:0]    s1;
    logic [NS-1:0]    s2;
    logic [NS-1:0]    s3;
    logic [NS-1:0]    flt;
    logic [NS-1:0]    next_flt;

    // Named filtered levels.
    logic             shutdown_n;
    logic             pok;
    logic             hot;
    logic             uvlo_pin;
    logic             pg_pin;
    logic [2:0]       above_lo;
    logic [2:0]       above_hi;
    logic [1:0]       ovf;
    logic [1:0]       zc;
    logic [1:0]       boot_sel;

    // Sequencer state.
    seq_state_e       state;
    seq_state_e       next_state;
    logic [VID_W-1:0] dac [NUM_REG];
    logic [VID_W-1:0] next_dac [NUM_REG];
    logic [VID_W-1:0] target [NUM_REG];
    logic [VID_W-1:0] next_target [NUM_REG];
    logic [VID_W-1:0] held_code;
    logic [VID_W-1:0] next_held_code;
    logic             held_valid;
    logic             next_held_valid;
    logic             uvlo_lat;
    logic             next_uvlo_lat;
    logic [2:0]       blank;
    logic [2:0]       next_blank;
    logic [SLEW_W-1:0] slew_cnt;
    logic [SLEW_W-1:0] next_slew_cnt;
    logic             shutdown_n_d;
    logic             pok_d;
    logic             pg_pin_d;
    logic             tm_start;
    logic             tm_abort;
    logic             tm_done;

    // Output state.
    logic             next_pg_oe;
    logic             next_th_oe;
    logic [1:0]       zc_lat;
    logic [1:0]       next_zc_lat;
    logic [1:0]       hg;
    logic [1:0]       next_hg;
    logic [1:0]       lg;
    logic [1:0]       next_lg;
    logic [1:0]       dis;
    logic [1:0]       next_dis;

    // Derived conditions.
    logic             sd;
    logic [2:0]       slewing;
    logic             any_slew;
    logic [2:0]       good;
    logic [VID_W-1:0] boot_code;
    logic [HOLD_W-1:0] hold_cnt;

    // Selects the boot code from the two link levels.
    function automatic logic [VID_W-1:0] boot_lookup(input logic [1:0] sel);
        logic [VID_W-1:0] code;
        unique case (sel)
            2'b00:   code = BOOT_CODE_0;
            2'b01:   code = BOOT_CODE_1;
            2'b10:   code = BOOT_CODE_2;
            2'b11:   code = BOOT_CODE_3;
        endcase
        return code;
    endfunction : boot_lookup

    // Gathers every asynchronous input except THERMAL_ALERT_N_I into one chain.
    assign pin_raw = {ZERO_CROSS, OUT_OVERVOLT, OUT_ABOVE_HIGH, OUT_ABOVE_LOW, POWER_GOOD_OUT_I,
                      SUPPLY_UVLO_IN, THERMAL_SENSE_IN, SERIAL_VID_DATA, SERIAL_VID_CLOCK,
                      SYSTEM_POWER_OK_IN, SHUTDOWN_N};

    // A level changes only once the second and third stages agree.
    always_comb begin
        next_flt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & flt);
    end

    // Registers the synchroniser chain.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            flt <= '0;
        end else begin
            s1  <= pin_raw;
            s2  <= s1;
            s3  <= s2;
            flt <= next_flt;
        end
    end

    // Splits the filtered levels and forms shared conditions.
    assign shutdown_n      = flt[0];
    assign pok       = flt[1];
    assign boot_sel  = {flt[2], flt[3]};
    assign hot       = flt[4];
    assign uvlo_pin  = flt[5];
    assign pg_pin    = flt[6];
    assign above_lo  = flt[9:7];
    assign above_hi  = flt[12:10];
    assign ovf       = flt[14:13];
    assign zc        = flt[16:15];
    assign sd        = !shutdown_n || uvlo_lat;
    assign boot_code = boot_lookup(boot_sel);
    assign any_slew  = |slewing;
    assign good      = above_lo & (~above_hi | blank); // RL13

    // Flags each output whose DAC has not reached its target.
    always_comb begin
        for (int i = 0; i < NUM_REG; i++) begin
            slewing[i] = (dac[i] != target[i]);
        end
    end

    // Sequencer, slew controller, held code and undervoltage latch.
    always_comb begin
        next_state      = state;
        next_dac        = dac;
        next_target     = target;
        next_held_code  = held_code;
        next_held_valid = held_valid;
        next_uvlo_lat   = uvlo_lat;
        next_blank      = blank;
        next_slew_cnt   = (slew_cnt == '0) ? SLEW_W'(SLEW_DIV - 1) : slew_cnt - SLEW_W'(1);
        tm_start        = 1'b0;
        tm_abort        = 1'b0;
        if (shutdown_n != shutdown_n_d) begin
            next_uvlo_lat = 1'b0; // RL19
        end
        if (shutdown_n && uvlo_pin) begin
            next_uvlo_lat = 1'b1; // RL19
        end
        if (shutdown_n && !shutdown_n_d) begin
            next_held_valid = 1'b0; // RL4
        end else if (state == ST_RUN && pg_pin && !pg_pin_d && !held_valid) begin
            next_held_code  = target[0]; // RL3
            next_held_valid = 1'b1; // RL7
        end
        for (int i = 0; i < NUM_REG; i++) begin
            if (slew_cnt == '0 && dac[i] < target[i]) begin
                next_dac[i] = dac[i] + VID_W'(1);
            end else if (slew_cnt == '0 && dac[i] > target[i]) begin
                next_dac[i] = dac[i] - VID_W'(1);
            end
            if (!slewing[i] && !above_hi[i]) begin
                next_blank[i] = 1'b0; // RL13
            end
        end
        unique case (state)
            ST_OFF: begin
                next_dac    = '{default: DAC_CODE_RST};
                next_target = '{default: boot_code};
                next_blank  = '0;
                next_state  = ST_BOOT;
            end
            ST_BOOT: begin
                next_target = '{default: boot_code}; // RL1
                if (!any_slew && target[0] == boot_code) begin
                    next_state = ST_BOOT_HOLD;
                    tm_start   = 1'b1; // RL11
                end
            end
            ST_BOOT_HOLD: begin
                if (target[0] != boot_code) begin
                    next_target = '{default: boot_code}; // RL1
                    next_state  = ST_BOOT;
                    tm_abort    = 1'b1;
                end else if (tm_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pok_d && !pok && held_valid) begin
                    next_target = '{default: held_code}; // RL5
                    next_state  = ST_FALL;
                end else if (CMD_VALID && pok) begin
                    for (int i = 0; i < NUM_REG; i++) begin
                        if (CMD_SELECT[i]) begin
                            next_target[i] = CMD_CODE; // RL2
                        end
                    end
                end
            end
            ST_FALL: begin
                if (!any_slew) begin
                    next_state = ST_FALL_HOLD;
                    tm_start   = 1'b1; // RL6
                end
            end
            ST_FALL_HOLD: begin
                if (tm_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        for (int i = 0; i < NUM_REG; i++) begin
            if (SKIP_MODE[i] && next_target[i] != target[i] && next_target[i] < dac[i]) begin
                next_blank[i] = 1'b1; // RL13
            end
        end
        if (sd) begin
            next_state = ST_OFF;
            tm_abort   = 1'b1;
        end
    end

    // Registers the sequencer group.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state      <= ST_OFF;
            dac        <= '{default: DAC_CODE_RST};
            target     <= '{default: DAC_CODE_RST};
            held_code  <= HELD_CODE_RST;
            held_valid <= 1'b0;
            uvlo_lat   <= 1'b0;
            blank      <= '0;
            slew_cnt   <= '0;
            shutdown_n_d     <= 1'b0;
            pok_d      <= 1'b0;
            pg_pin_d   <= 1'b0;
        end else begin
            state      <= next_state;
            dac        <= next_dac;
            target     <= next_target;
            held_code  <= next_held_code;
            held_valid <= next_held_valid;
            uvlo_lat   <= next_uvlo_lat;
            blank      <= next_blank;
            slew_cnt   <= next_slew_cnt;
            shutdown_n_d     <= shutdown_n;
            pok_d      <= pok;
            pg_pin_d   <= pg_pin;
        end
    end

    // Extension timer for both the boot and the fallback hold.
    pg_ext_timer #(
        .CYCLES (PG_EXT_CYCLES)
    ) u_pg_ext_timer (
        .clk     (SYS_CLK),
        .rst_n   (RST_N),
        .start   (tm_start), // RL20
        .abort   (tm_abort),
        .expired (tm_done)
    );

    // Power good, thermal alert, gate overrides and discharge.
    always_comb begin
        next_pg_oe = 1'b1; // RL12
        if (!sd && state == ST_RUN) begin
            // Power ok level is not used here, only its fall picks the fallback state.
            next_pg_oe = any_slew ? 1'b0 : !(&good); // RL8 RL9 RL10
        end
        next_th_oe = !sd && hot; // RL18
        for (int i = 0; i < 2; i++) begin
            next_zc_lat[i] = zc_lat[i];
            if (PWM_HIGH_REQ[i]) begin
                next_zc_lat[i] = 1'b0;
            end
            if (SKIP_MODE[i] && zc[i]) begin
                next_zc_lat[i] = 1'b1; // RL15
            end
            next_hg[i] = !sd && PWM_HIGH_REQ[i] && !ovf[i]; // RL16
            if (sd) begin
                next_lg[i] = 1'b0; // RL14
            end else if (ovf[i]) begin
                next_lg[i] = 1'b1; // RL14
            end else if (next_zc_lat[i]) begin
                next_lg[i] = 1'b0; // RL15
            end else begin
                next_lg[i] = PWM_LOW_REQ[i];
            end
            next_dis[i] = sd; // RL17
        end
    end

    // Registers the output group; open-drain data stays low.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            POWER_GOOD_OUT_O   <= 1'b0;
            POWER_GOOD_OUT_OE  <= 1'b1;
            THERMAL_ALERT_N_O  <= 1'b0;
            THERMAL_ALERT_N_OE <= 1'b0;
            zc_lat             <= '0;
            hg                 <= '0;
            lg                 <= '0;
            dis                <= 2'h3;
        end else begin
            POWER_GOOD_OUT_O   <= 1'b0;
            POWER_GOOD_OUT_OE  <= next_pg_oe;
            THERMAL_ALERT_N_O  <= 1'b0;
            THERMAL_ALERT_N_OE <= next_th_oe;
            zc_lat             <= next_zc_lat;
            hg                 <= next_hg;
            lg                 <= next_lg;
            dis                <= next_dis;
        end
    end

    // Drives ports from their flip-flops.
    assign HIGH_SIDE_GATE_1              = hg[0];
    assign HIGH_SIDE_GATE_2              = hg[1];
    assign LOW_SIDE_GATE_1               = lg[0];
    assign LOW_SIDE_GATE_2               = lg[1];
    assign CURRENT_SENSE_NEG_1_DISCHARGE = dis[0];
    assign CURRENT_SENSE_NEG_2_DISCHARGE = dis[1];
    assign DAC_CODE_1                    = dac[0];
    assign DAC_CODE_2                    = dac[1];
    assign DAC_CODE_3                    = dac[2];

    // Counts cycles spent in a hold state, for the checks below.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold_cnt <= '0;
        end else if (state != ST_BOOT_HOLD && state != ST_FALL_HOLD) begin
            hold_cnt <= '0;
        end else if (hold_cnt != '1) begin
            hold_cnt <= hold_cnt + HOLD_W'(1);
        end
    end

    AST_SD_PG_LOW: assert property ( // RL12
        @(posedge SYS_CLK) disable iff (!RST_N) sd |=> POWER_GOOD_OUT_OE)
        else $error("Power good not driven low in shutdown.");

    AST_HOLD_LEN: assert property ( // RL6 RL11 RL20
        @(posedge SYS_CLK) disable iff (!RST_N)
        ((state == ST_BOOT_HOLD || state == ST_FALL_HOLD) && tm_done) |-> hold_cnt >= PG_EXT_CYCLES)
        else $error("Power good hold shorter than the extension time.");

    AST_FALLBACK: assert property ( // RL5
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state == ST_RUN && pok_d && !pok && held_valid && !sd)
        |=> (state == ST_FALL) && (target[1] == held_code) ##1 POWER_GOOD_OUT_OE)
        else $error("Fallback to the held boot code did not start.");

    AST_HELD_CLEAR: assert property ( // RL4
        @(posedge SYS_CLK) disable iff (!RST_N) (shutdown_n && !shutdown_n_d) |=> !held_valid)
        else $error("Held boot code not cleared by shutdown release.");

    AST_HELD_KEEP: assert property ( // RL7
        @(posedge SYS_CLK) disable iff (!RST_N)
        (held_valid && !(shutdown_n && !shutdown_n_d)) |=> held_valid && $stable(held_code))
        else $error("Held boot code changed while valid.");

    AST_CAPTURE: assert property ( // RL3
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state == ST_RUN && $rose(pg_pin) && !held_valid && shutdown_n_d)
        |=> held_valid && held_code == $past(target[0]))
        else $error("Boot code not captured at power good rise.");

    AST_SLEW_RELEASE: assert property ( // RL10
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state == ST_RUN && !sd && any_slew) |=> !POWER_GOOD_OUT_OE)
        else $error("Power good not released during a slew.");

    AST_OV_LOW_GATE: assert property ( // RL14
        @(posedge SYS_CLK) disable iff (!RST_N) (!sd && ovf[0]) |=> LOW_SIDE_GATE_1 && !HIGH_SIDE_GATE_1)
        else $error("Low gate not forced on by overvoltage.");

    AST_SD_HIGH_GATE: assert property ( // RL16
        @(posedge SYS_CLK) disable iff (!RST_N)
        sd |=> !HIGH_SIDE_GATE_1 && !HIGH_SIDE_GATE_2 && CURRENT_SENSE_NEG_2_DISCHARGE)
        else $error("Gates or discharge wrong in shutdown.");

    AST_UVLO_LATCH: assert property ( // RL19
        @(posedge SYS_CLK) disable iff (!RST_N) (shutdown_n && uvlo_pin) |=> uvlo_lat)
        else $error("Undervoltage event not latched.");

    AST_THERMAL: assert property ( // RL18
        @(posedge SYS_CLK) disable iff (!RST_N) (!sd && hot) |=> THERMAL_ALERT_N_OE)
        else $error("Thermal alert not pulled low.");

endmodule : boot_voltage_power_good_seq

//--- host_platform_model.sv
/*
  Model of the host link levels and the platform power ok logic.
  Assumes the power good wire is resolved with a pull-up by the bench.
*/
`timescale 1ns/10ps
module host_platform_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bench control and the wire seen.
    input  wire logic [1:0] boot_sel,
    input  wire logic       drop,
    input  wire logic       pg_wire,
    // Link levels and power ok.
    output logic            serial_vid_clock,
    output logic            serial_vid_data,
    output logic            pok
);
    logic [3:0] seen;
    // Power ok rises only once power good has stood high for a while.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 4'h0;
            pok  <= 1'b0;
        end else begin
            seen <= (pg_wire && !drop) ? seen + {3'h0, seen != 4'hf} : 4'h0;
            pok  <= !drop && (pok || seen == 4'hf);
        end
    end
    // Boot levels follow the selection of the bench.
    assign serial_vid_clock = boot_sel[1];
    assign serial_vid_data = boot_sel[0];
endmodule : host_platform_model

//--- boot_voltage_power_good_seq_tb.sv
/*
  Self-checking bench of the boot and power good sequencer.
  Assumes a small slew divider and a pull-up on both open-drain wires.
*/
`timescale 1ns/10ps
module boot_voltage_power_good_seq_tb;
    import boot_seq_pkg::*;
    logic SYS_CLK, RST_N, SHUTDOWN_N, THERMAL_SENSE_IN, SUPPLY_UVLO_IN, CMD_VALID, drop;
    logic [2:0] OUT_ABOVE_LOW, OUT_ABOVE_HIGH, CMD_SELECT, SKIP_MODE;
    logic [1:0] OUT_OVERVOLT, ZERO_CROSS, PWM_HIGH_REQ, PWM_LOW_REQ, boot_sel;
    logic [VID_W-1:0] CMD_CODE, DAC_CODE_1, dac2;
    logic serial_vid_clock, serial_vid_data, pok, pg_o, pg_oe, th_o, th_oe, hs1, hs2, ls1, ls2, dis1, dis2;
    wire pg_wire = pg_oe ? pg_o : 1'b1;
    wire th_wire = th_oe ? th_o : 1'b1;
    int fail_count, n_checks, n;
    // Gate rows: overvolt, high request, low request, then expected high and low gate.
    logic [4:0] rows [4] = '{5'b000_00, 5'b010_10, 5'b001_01, 5'b110_01};
    boot_voltage_power_good_seq #(.SLEW_DIV(2)) dut_u (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SHUTDOWN_N(SHUTDOWN_N), .SYSTEM_POWER_OK_IN(pok),
        .SERIAL_VID_CLOCK(serial_vid_clock), .SERIAL_VID_DATA(serial_vid_data), .THERMAL_SENSE_IN(THERMAL_SENSE_IN),
        .SUPPLY_UVLO_IN(SUPPLY_UVLO_IN), .POWER_GOOD_OUT_I(pg_wire), .THERMAL_ALERT_N_I(th_wire),
        .OUT_ABOVE_LOW(OUT_ABOVE_LOW), .OUT_ABOVE_HIGH(OUT_ABOVE_HIGH), .OUT_OVERVOLT(OUT_OVERVOLT),
        .ZERO_CROSS(ZERO_CROSS), .CMD_VALID(CMD_VALID), .CMD_SELECT(CMD_SELECT), .CMD_CODE(CMD_CODE),
        .SKIP_MODE(SKIP_MODE), .PWM_HIGH_REQ(PWM_HIGH_REQ), .PWM_LOW_REQ(PWM_LOW_REQ),
        .POWER_GOOD_OUT_O(pg_o), .POWER_GOOD_OUT_OE(pg_oe), .THERMAL_ALERT_N_O(th_o),
        .THERMAL_ALERT_N_OE(th_oe), .HIGH_SIDE_GATE_1(hs1), .HIGH_SIDE_GATE_2(hs2),
        .LOW_SIDE_GATE_1(ls1), .LOW_SIDE_GATE_2(ls2), .CURRENT_SENSE_NEG_1_DISCHARGE(dis1),
        .CURRENT_SENSE_NEG_2_DISCHARGE(dis2), .DAC_CODE_1(DAC_CODE_1), .DAC_CODE_2(dac2), .DAC_CODE_3()
    );
    host_platform_model host_u (.clk(SYS_CLK), .rst_n(RST_N), .boot_sel(boot_sel), .drop(drop),
        .pg_wire(pg_wire), .serial_vid_clock(serial_vid_clock), .serial_vid_data(serial_vid_data), .pok(pok));
    // Free running clock.
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    // Steps past edges and lands just after the last one.
    task step(input int k);
        repeat (k) @(posedge SYS_CLK);
        #1;
    endtask : step
    // Compares a seen value with the expected one.
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Waits for the first DAC to reach a code, bounded.
    task wait_dac(input logic [VID_W-1:0] code);
        for (n = 0; DAC_CODE_1 !== code && n < 500; n++) step(1);
        chk({1'b0, DAC_CODE_1}, {1'b0, code});
    endtask : wait_dac
    // Counts cycles until power good is released, then checks the extension.
    task pg_ext();
        for (n = 0; pg_oe !== 1'b0 && n < 4000; n++) step(1);
        chk({7'h0, n >= PG_EXT_CYCLES && n < 4000}, 8'h01);
    endtask : pg_ext
    // Drops power ok and checks the return to the held boot code.
    task fall_back();
        drop = 1'b1;
        step(8);
        chk({7'h0, pg_oe}, 8'h01);
        wait_dac(7'h40);
        pg_ext();
        drop = 1'b0;
        step(40);
    endtask : fall_back
    // Sends one command to the first regulator.
    task cmd(input logic [VID_W-1:0] code);
        CMD_SELECT = 3'b001;
        CMD_CODE   = code;
        CMD_VALID  = 1'b1;
        step(1);
        CMD_VALID  = 1'b0;
        step(3);
    endtask : cmd
    // Prints the counts and the verdict, then ends the run.
    task wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // Watchdog sized well past the expected run.
    initial begin
        #300_000;
        fail_count++;
        wrap_up();
    end
    // Main sequence.
    initial begin
        {RST_N, SHUTDOWN_N, THERMAL_SENSE_IN, SUPPLY_UVLO_IN, CMD_VALID, drop} = 6'h00;
        {OUT_ABOVE_HIGH, SKIP_MODE, CMD_SELECT, OUT_OVERVOLT, ZERO_CROSS, PWM_LOW_REQ} = 15'h0000;
        OUT_ABOVE_LOW = 3'b111;
        PWM_HIGH_REQ  = 2'b11;
        boot_sel      = 2'b10;
        CMD_CODE      = 7'h00;
        step(8);
        chk({dis1, dis2, pg_oe, pg_o, th_o, 3'h0}, 8'he0);
        RST_N = 1'b1;
        THERMAL_SENSE_IN = 1'b1;
        step(10);
        chk({hs1, hs2, ls1, ls2, th_oe, dis1, 2'h0}, 8'h04);
        $display("shutdown test done");
        THERMAL_SENSE_IN = 1'b0;
        SHUTDOWN_N = 1'b1;
        step(20);
        boot_sel = 2'b11;
        wait_dac(7'h40);
        chk({1'b0, dac2}, 8'h40);
        pg_ext();
        step(40);
        cmd(7'h50);
        chk({7'h0, pg_oe}, 8'h00);
        wait_dac(7'h50);
        step(4);
        OUT_ABOVE_LOW = 3'b011;
        step(6);
        chk({7'h0, pg_oe}, 8'h01);
        OUT_ABOVE_LOW = 3'b111;
        THERMAL_SENSE_IN = 1'b1;
        step(6);
        chk({6'h0, pg_oe, th_oe}, 8'h01);
        THERMAL_SENSE_IN = 1'b0;
        $display("boot and command test done");
        foreach (rows[i]) begin
            {OUT_OVERVOLT, PWM_HIGH_REQ, PWM_LOW_REQ} = {{2{rows[i][4]}}, {2{rows[i][3]}}, {2{rows[i][2]}}};
            step(6);
            chk({4'h0, hs1, ls1, hs2, ls2}, {4'h0, rows[i][1:0], rows[i][1:0]});
        end
        {OUT_OVERVOLT, PWM_LOW_REQ, PWM_HIGH_REQ} = 6'h03;
        $display("gate test done");
        fall_back();
        cmd(7'h30);
        wait_dac(7'h30);
        fall_back();
        $display("fallback test done");
        SUPPLY_UVLO_IN = 1'b1;
        step(5);
        SUPPLY_UVLO_IN = 1'b0;
        step(10);
        chk({6'h0, hs1, pg_oe}, 8'h01);
        SHUTDOWN_N = 1'b0;
        step(10);
        SHUTDOWN_N = 1'b1;
        step(10);
        chk({7'h0, hs1}, 8'h01);
        $display("undervoltage test done");
        wrap_up();
    end
endmodule : boot_voltage_power_good_seq_tb
